// ===== hdl/psc_map.vh
// register map, field codes and timing figures of the setpoint controller
// assumes a 32-bit register port with byte addresses on 10 bits
`ifndef PSC_MAP_VH
`define PSC_MAP_VH
`define PSC_CTRL_ADDR 10'h100
`define PSC_CTRL_LBL_RST 0
`define PSC_CH_ADDR_BIT 9
`define PSC_CH_CFG 2'h0
`define PSC_CH_ON 2'h1
`define PSC_CH_OFF 2'h2
`define PSC_CH_DLY 2'h3
`define PSC_SN_CFG 3'h0
`define PSC_SN_SET 3'h1
`define PSC_SN_AUTO 3'h2
`define PSC_SN_LBL_LO 3'h3
`define PSC_SN_LBL_HI 3'h4
`define PSC_SN_STAT 3'h5
`define PSC_CFG_SEL_LSB 0
`define PSC_CFG_MODE_LSB 4
`define PSC_CFG_ERR_BIT 8
`define PSC_CFG_ACT_BIT 9
`define PSC_CFG_PEND_BIT 10
`define PSC_SN_MODEL_LSB 0
`define PSC_SN_FAST_BIT 4
`define PSC_SN_LINK_LSB 5
`define PSC_SN_MAN_BIT 9
`define PSC_SN_FIL2_BIT 10
`define PSC_MODE_AUTO 2'h0
`define PSC_MODE_ON 2'h1
`define PSC_MODE_OFF 2'h2
`define PSC_KIND_HOT_FILAMENT_GAUGE_ID 2'h0
`define PSC_KIND_CNV 2'h1
`define PSC_KIND_IMG 2'h2
`define PSC_KIND_AUX 2'h3
`define PSC_MODEL_HF_DEF 4'h6
`define PSC_MODEL_IMG_DEF 4'h8
`define PSC_CLK_HZ 200000000
`define PSC_FAST_MS 10
`define PSC_SLOW_MS 250
`define PSC_DLY_TICK_MS 100
`define PSC_HYST_UT 32'h0000_1388
`define PSC_AUTO_MAX_UT 32'h000F_4240
`define PSC_AUTO_DEF_UT 32'h0000_1388
`define PSC_OP_HI_UT 32'h0000_2710
`define PSC_OP_LO_UT 32'h0000_03E8
`define PSC_EMIS_SPLIT 16'h0007
`define PSC_PFX_HOT_FILAMENT_GAUGE_ID 32'h4846_4947
`define PSC_PFX_CNV 24'h434E56
`define PSC_PFX_IMG 24'h494D47
`define PSC_PFX_AUX 24'h415558
`endif

// ===== hdl/psc_setpoint_ctrl.v
// setpoint channels, ion gauge control, analog update pacing and sensor labels
// assumes pressures come from same-clock sensor logic, linear in microtorr
// Function
// - eight setpoint channels, each fixed to one rear output, numbering fixed.
// - at most two channels per sensor; a third assignment is refused.
// - selecting no sensor zeroes thresholds and delays and forces OFF.
// - auto mode, pressure below ON threshold drives output active, low.
// - auto mode, pressure above OFF threshold returns output inactive.
// - ON threshold not below OFF threshold flags error; valid returns to auto.
// - ON delay in 100 ms steps passes before output, indicator, status activate.
// - OFF delay in 100 ms steps passes before output, indicator, status deactivate.
// - auto is default mode; output comes only from threshold comparison.
// - forced ON/OFF override output and keep thresholds and delays.
// - linked ion gauge ignores manual on/off, follows linked pressure.
// - auto gauge on below threshold up to 1T, off at threshold plus 5mT.
// - analog output updates every 10 ms fast or 250 ms slow.
// - analog rate defaults fast for magnetron, slow for other gauges.
// - variable-limit hot gauges use 10 mT at or below 0.7 mA, else 1 mT.
// - model change reloads sensitivity and emission current defaults.
// - label at most five alphanumerics, reserved identifier prefixes refused.
// - unset label equals identifier; label reset restores identifiers.
// - identifiers follow install order; numbers 10 to 12 become letters.
// - second filament request on single-filament sensor raises fault.
//
// The placing of the registers and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
`include "psc_map.vh"
`default_nettype none
module psc_setpoint_ctrl #(
    parameter NSENS = 12,
    parameter [2*NSENS-1:0] SENSOR_KINDS = 24'h55_55A0,
    parameter TICK_CYC = `PSC_CLK_HZ / 1000 * `PSC_FAST_MS
) (
    // clock and reset
    input wire clk_in,
    input wire arst_n_in,
    // register port
    input wire [9:0] reg_addr_in,
    input wire [31:0] reg_wdata_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    output reg [31:0] reg_rdata_out,
    // sensor pressures, 32 bits each
    input wire [NSENS*32-1:0] pressure_in,
    // setpoint outputs
    output wire [7:0] setpoint_active_out,
    output wire [7:0] setpoint_oc_n_out,
    output wire [7:0] setpoint_error_out,
    // gauge control
    output wire [NSENS-1:0] gauge_on_out,
    output wire [NSENS-1:0] filament_two_out,
    output wire [NSENS-1:0] missing_filament_fault_out,
    output wire [NSENS-1:0] overpressure_out,
    // analog outputs
    output wire [NSENS-1:0] analog_update_out,
    output wire [NSENS*32-1:0] analog_level_out
);
    localparam DLY_DIV = `PSC_DLY_TICK_MS / `PSC_FAST_MS;
    localparam SLOW_DIV = `PSC_SLOW_MS / `PSC_FAST_MS;

    // model table: {variable limit, two filaments, emission 0.1mA, sensitivity 0.1}
    function [17:0] model_def;
        input [3:0] m;
        begin
            case (m)
                4'h0: model_def = {2'b10, 8'h01, 8'hC8};
                4'h1: model_def = {2'b11, 8'h01, 8'hFA};
                4'h2: model_def = {2'b10, 8'h28, 8'h64};
                4'h3: model_def = {2'b01, 8'h28, 8'h64};
                4'h4: model_def = {2'b10, 8'h28, 8'h64};
                4'h5: model_def = {2'b10, 8'h01, 8'h3C};
                4'h6: model_def = {2'b01, 8'h28, 8'hFA};
                4'h7: model_def = {2'b01, 8'h28, 8'hC8};
                4'h8: model_def = {2'b00, 8'h00, 8'h14};
                4'h9: model_def = {2'b00, 8'h00, 8'h19};
                default: model_def = {2'b00, 8'h00, 8'h00};
            endcase
        end
    endfunction

    function alnum;
        input [7:0] c;
        begin
            alnum = (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h5A) ||
                (c >= 8'h61 && c <= 8'h7A);
        end
    endfunction

    // shared time base: 10 ms tick, 100 ms delay tick, 250 ms slow tick
    reg [31:0] base_cnt_q;
    reg [7:0] dly_div_q;
    reg [7:0] slow_div_q;
    wire tick_fast = (base_cnt_q == TICK_CYC - 1);
    wire tick_dly = tick_fast && (dly_div_q == DLY_DIV - 1);
    wire tick_slow = tick_fast && (slow_div_q == SLOW_DIV - 1);

    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            base_cnt_q <= 32'h0000_0000;
            dly_div_q <= 8'h00;
            slow_div_q <= 8'h00;
        end else begin
            base_cnt_q <= tick_fast ? 32'h0000_0000 : base_cnt_q + 32'h0000_0001;
            if (tick_fast) begin
                dly_div_q <= tick_dly ? 8'h00 : dly_div_q + 8'h01;
                slow_div_q <= tick_slow ? 8'h00 : slow_div_q + 8'h01;
            end
        end
    end

    wire ch_wr = reg_wr_in && !reg_addr_in[`PSC_CH_ADDR_BIT] && !reg_addr_in[8] &&
        !reg_addr_in[7];
    wire sn_wr = reg_wr_in && reg_addr_in[`PSC_CH_ADDR_BIT];
    wire lbl_rst = reg_wr_in && reg_addr_in == `PSC_CTRL_ADDR &&
        reg_wdata_in[`PSC_CTRL_LBL_RST];
    wire [3:0] new_sel = reg_wdata_in[`PSC_CFG_SEL_LSB +: 4];
    wire [8*4-1:0] sel_all;
    wire [8*32-1:0] ch_word;
    wire [NSENS*32-1:0] sn_word;

    genvar c;
    genvar s;
    // one block per setpoint channel, number fixed by position
    generate
        for (c = 0; c < 8; c = c + 1) begin : g_ch
            reg [3:0] sel_q;
            reg [1:0] mode_q;
            reg [31:0] on_q;
            reg [31:0] off_q;
            reg [15:0] ond_q;
            reg [15:0] offd_q;
            reg [15:0] cnt_q;
            reg act_q;
            reg [31:0] p;
            reg [2:0] others;
            reg [31:0] rd;
            integer k;
            wire hit = ch_wr && reg_addr_in[6:4] == c;
            wire err = sel_q != 4'h0 && on_q >= off_q;
            wire autom = mode_q == `PSC_MODE_AUTO && !err && sel_q != 4'h0;
            // wanted state from comparison, hysteresis kept by act_q
            wire want = act_q ? !(p > off_q) : (p < on_q);
            wire pend = autom && want != act_q;
            wire [15:0] dly = act_q ? offd_q : ond_q;
            wire sel_ok = new_sel == 4'h0 || (new_sel <= NSENS && others < 3'h2);

            always @* begin
                p = 32'h0000_0000;
                others = 3'h0;
                for (k = 0; k < NSENS; k = k + 1) begin
                    if (sel_q == k[3:0] + 4'h1) begin
                        p = pressure_in[k*32 +: 32];
                    end
                end
                for (k = 0; k < 8; k = k + 1) begin
                    if (k != c && sel_all[k*4 +: 4] == new_sel) begin
                        others = others + 3'h1;
                    end
                end
                case (reg_addr_in[3:2])
                    `PSC_CH_CFG: rd = {21'h0, pend, act_q, err, 2'h0, mode_q, sel_q};
                    `PSC_CH_ON: rd = on_q;
                    `PSC_CH_OFF: rd = off_q;
                    default: rd = {offd_q, ond_q};
                endcase
            end

            always @(posedge clk_in or negedge arst_n_in) begin
                if (!arst_n_in) begin
                    sel_q <= 4'h0;
                    mode_q <= `PSC_MODE_AUTO;
                    on_q <= 32'h0000_0000;
                    off_q <= 32'h0000_0000;
                    ond_q <= 16'h0000;
                    offd_q <= 16'h0000;
                    cnt_q <= 16'h0000;
                    act_q <= 1'b0;
                end else begin
                    if (hit && reg_addr_in[3:2] == `PSC_CH_CFG) begin
                        mode_q <= reg_wdata_in[`PSC_CFG_MODE_LSB +: 2];
                        if (sel_ok) begin
                            sel_q <= new_sel;
                        end
                        if (sel_ok && new_sel == 4'h0) begin
                            on_q <= 32'h0000_0000;
                            off_q <= 32'h0000_0000;
                            ond_q <= 16'h0000;
                            offd_q <= 16'h0000;
                            mode_q <= `PSC_MODE_OFF;
                        end
                    end
                    if (hit && reg_addr_in[3:2] == `PSC_CH_ON) begin
                        on_q <= reg_wdata_in;
                    end
                    if (hit && reg_addr_in[3:2] == `PSC_CH_OFF) begin
                        off_q <= reg_wdata_in;
                    end
                    if (hit && reg_addr_in[3:2] == `PSC_CH_DLY) begin
                        ond_q <= reg_wdata_in[15:0];
                        offd_q <= reg_wdata_in[31:16];
                    end
                    if (mode_q == `PSC_MODE_ON) begin
                        act_q <= 1'b1;
                        cnt_q <= 16'h0000;
                    end else if (!autom) begin
                        act_q <= 1'b0;
                        cnt_q <= 16'h0000;
                    end else if (!pend) begin
                        cnt_q <= 16'h0000;
                    end else if (cnt_q >= dly) begin
                        act_q <= want;
                        cnt_q <= 16'h0000;
                    end else if (tick_dly) begin
                        cnt_q <= cnt_q + 16'h0001;
                    end
                end
            end

            assign sel_all[c*4 +: 4] = sel_q;
            assign ch_word[c*32 +: 32] = rd;
            assign setpoint_active_out[c] = act_q;
            assign setpoint_oc_n_out[c] = !act_q;
            assign setpoint_error_out[c] = err;
        end

        // one block per sensor in installation order
        for (s = 0; s < NSENS; s = s + 1) begin : g_sn
            localparam [1:0] KIND = SENSOR_KINDS[2*s+1:2*s];
            localparam [3:0] DEF_MODEL =
                KIND == `PSC_KIND_IMG ? `PSC_MODEL_IMG_DEF : `PSC_MODEL_HF_DEF;
            localparam [17:0] DEF = model_def(DEF_MODEL);
            localparam IS_ION = KIND == `PSC_KIND_HOT_FILAMENT_GAUGE_ID || KIND == `PSC_KIND_IMG;
            reg [3:0] model_q;
            reg fast_q;
            reg [3:0] link_q;
            reg man_q;
            reg fil2_q;
            reg [15:0] sens_q;
            reg [15:0] emis_q;
            reg [31:0] athr_q;
            reg [31:0] stage_q;
            reg [39:0] lbl_q;
            reg lbl_set_q;
            reg rej_q;
            reg on_q;
            reg ov_q;
            reg [31:0] ana_q;
            reg upd_q;
            reg [31:0] lp;
            reg [4:0] num;
            reg [39:0] id;
            reg [39:0] eff;
            reg [31:0] rd;
            integer k;
            wire [31:0] p = pressure_in[s*32 +: 32];
            wire hit = sn_wr && reg_addr_in[8:5] == s;
            wire [17:0] tab = model_def(model_q);
            wire [17:0] newtab = model_def(reg_wdata_in[`PSC_SN_MODEL_LSB +: 4]);
            wire [3:0] new_link = reg_wdata_in[`PSC_SN_LINK_LSB +: 4];
            wire [39:0] cand = {stage_q, reg_wdata_in[7:0]};
            // overpressure limit chosen from emission current on variable-limit hot gauges, fixed for the others
            wire [31:0] lim = KIND == `PSC_KIND_IMG ? `PSC_OP_HI_UT :
                (tab[17] && emis_q <= `PSC_EMIS_SPLIT) ? `PSC_OP_HI_UT :
                `PSC_OP_LO_UT;
            wire over = IS_ION && on_q && p > lim;
            wire lbl_ok = alnum(cand[39:32]) &&
                (alnum(cand[31:24]) || cand[31:24] == 8'h00) &&
                (alnum(cand[23:16]) || cand[23:16] == 8'h00) &&
                (alnum(cand[15:8]) || cand[15:8] == 8'h00) &&
                (alnum(cand[7:0]) || cand[7:0] == 8'h00) &&
                cand[39:8] != `PSC_PFX_HOT_FILAMENT_GAUGE_ID && cand[39:16] != `PSC_PFX_CNV &&
                cand[39:16] != `PSC_PFX_IMG && cand[39:16] != `PSC_PFX_AUX;

            always @* begin
                lp = 32'h0000_0000;
                num = 5'h01;
                for (k = 0; k < NSENS; k = k + 1) begin
                    if (link_q == k[3:0] + 4'h1) begin
                        lp = pressure_in[k*32 +: 32];
                    end
                    if (k < s && SENSOR_KINDS[2*k +: 2] == KIND) begin
                        num = num + 5'h01;
                    end
                end
                if (num < 5'h0A) begin
                    id[15:8] = 8'h30 + {3'h0, num};
                end else begin
                    id[15:8] = 8'h41 + {3'h0, num - 5'h0A};
                end
                case (KIND)
                    `PSC_KIND_HOT_FILAMENT_GAUGE_ID: id = {`PSC_PFX_HOT_FILAMENT_GAUGE_ID, id[15:8]};
                    `PSC_KIND_CNV: id = {`PSC_PFX_CNV, id[15:8], 8'h00};
                    `PSC_KIND_IMG: id = {`PSC_PFX_IMG, id[15:8], 8'h00};
                    default: id = {`PSC_PFX_AUX, id[15:8], 8'h00};
                endcase
                eff = lbl_set_q ? lbl_q : id;
                case (reg_addr_in[4:2])
                    `PSC_SN_CFG: rd = {21'h0, fil2_q, man_q, link_q, fast_q, model_q};
                    `PSC_SN_SET: rd = {emis_q, sens_q};
                    `PSC_SN_AUTO: rd = athr_q;
                    `PSC_SN_LBL_LO: rd = eff[39:8];
                    `PSC_SN_LBL_HI: rd = {24'h0, eff[7:0]};
                    `PSC_SN_STAT: rd = {26'h0, lbl_set_q, rej_q, ov_q,
                        missing_filament_fault_out[s], on_q, fast_q};
                    default: rd = 32'h0000_0000;
                endcase
            end

            always @(posedge clk_in or negedge arst_n_in) begin
                if (!arst_n_in) begin
                    model_q <= DEF_MODEL;
                    fast_q <= KIND == `PSC_KIND_IMG;
                    link_q <= 4'h0;
                    man_q <= 1'b0;
                    fil2_q <= 1'b0;
                    sens_q <= {8'h00, DEF[7:0]};
                    emis_q <= {8'h00, DEF[15:8]};
                    athr_q <= `PSC_AUTO_DEF_UT;
                    stage_q <= 32'h0000_0000;
                    lbl_q <= 40'h00_0000_0000;
                    lbl_set_q <= 1'b0;
                    rej_q <= 1'b0;
                    on_q <= !IS_ION;
                    ov_q <= 1'b0;
                    ana_q <= 32'h0000_0000;
                    upd_q <= 1'b0;
                end else begin
                    if (hit && reg_addr_in[4:2] == `PSC_SN_CFG) begin
                        fast_q <= reg_wdata_in[`PSC_SN_FAST_BIT];
                        fil2_q <= reg_wdata_in[`PSC_SN_FIL2_BIT];
                        link_q <= new_link <= NSENS ? new_link : 4'h0;
                        if (link_q == 4'h0) begin
                            man_q <= reg_wdata_in[`PSC_SN_MAN_BIT];
                        end
                        if (IS_ION && reg_wdata_in[3:0] != model_q) begin
                            model_q <= reg_wdata_in[3:0];
                            sens_q <= {8'h00, newtab[7:0]};
                            emis_q <= {8'h00, newtab[15:8]};
                            fast_q <= KIND == `PSC_KIND_IMG;
                        end
                    end
                    if (hit && reg_addr_in[4:2] == `PSC_SN_SET) begin
                        sens_q <= reg_wdata_in[15:0];
                        emis_q <= reg_wdata_in[31:16];
                    end
                    if (hit && reg_addr_in[4:2] == `PSC_SN_AUTO) begin
                        athr_q <= reg_wdata_in > `PSC_AUTO_MAX_UT ?
                            `PSC_AUTO_MAX_UT : reg_wdata_in;
                    end
                    if (hit && reg_addr_in[4:2] == `PSC_SN_LBL_LO) begin
                        stage_q <= reg_wdata_in;
                    end
                    if (hit && reg_addr_in[4:2] == `PSC_SN_LBL_HI) begin
                        rej_q <= !lbl_ok;
                        if (lbl_ok) begin
                            lbl_q <= cand;
                            lbl_set_q <= 1'b1;
                        end
                    end else if (lbl_rst) begin
                        lbl_set_q <= 1'b0;
                    end
                    // gauge on/off: linked pressure wins over manual
                    if (!IS_ION) begin
                        on_q <= 1'b1;
                    end else if (over) begin
                        on_q <= 1'b0;
                        ov_q <= 1'b1;
                        man_q <= 1'b0;
                    end else if (link_q != 4'h0) begin
                        if (lp >= athr_q + `PSC_HYST_UT) begin
                            on_q <= 1'b0;
                            ov_q <= 1'b0;
                        end else if (lp < athr_q && !ov_q) begin
                            on_q <= 1'b1;
                        end
                    end else begin
                        on_q <= man_q;
                        if (man_q) begin
                            ov_q <= 1'b0;
                        end
                    end
                    upd_q <= fast_q ? tick_fast : tick_slow;
                    if (fast_q ? tick_fast : tick_slow) begin
                        ana_q <= p;
                    end
                end
            end

            assign sn_word[s*32 +: 32] = rd;
            assign gauge_on_out[s] = on_q;
            assign filament_two_out[s] = on_q && fil2_q && tab[16];
            assign missing_filament_fault_out[s] =
                KIND == `PSC_KIND_HOT_FILAMENT_GAUGE_ID && fil2_q && !tab[16];
            assign overpressure_out[s] = ov_q;
            assign analog_update_out[s] = upd_q;
            assign analog_level_out[s*32 +: 32] = ana_q;
        end
    endgenerate

    // read data stand only in the cycle after the strobe
    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            reg_rdata_out <= 32'h0000_0000;
        end else if (!reg_rd_in) begin
            reg_rdata_out <= 32'h0000_0000;
        end else if (!reg_addr_in[9] && !reg_addr_in[8] && reg_addr_in[7] == 1'b0) begin
            reg_rdata_out <= ch_word[reg_addr_in[6:4]*32 +: 32];
        end else if (reg_addr_in[9] && reg_addr_in[8:5] < NSENS) begin
            reg_rdata_out <= sn_word[reg_addr_in[8:5]*32 +: 32];
        end else begin
            reg_rdata_out <= 32'h0000_0000;
        end
    end
endmodule // psc_setpoint_ctrl
`default_nettype wire

// ===== verification/pressure_setpoint_controller_bench.sv
// self-checking bench of the setpoint controller
// assumes the sensor stand-in and the bound checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module pressure_setpoint_controller_bench;
    logic clk_in = 1'b0, arst_n_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0, exp_act = 1'b1;
    logic [9:0] reg_addr_in = 10'h000;
    logic [31:0] reg_wdata_in = 32'h0, target = 32'h0000_0800, p;
    integer seed = 32'h34E8A773;
    int n_errors = 0, checked = 0;
    wire [31:0] reg_rdata_out;
    wire [383:0] pressure;
    wire [7:0] act, oc_n, err;
    always #2.5 clk_in = ~clk_in;
    psc_sensor_model i_psc_sensor_model (.clk_in(clk_in), .idx_in(4'h4), .target_in(target),
        .pressure_out(pressure));
    psc_setpoint_ctrl #(.TICK_CYC(2)) i_psc_setpoint_ctrl (.clk_in(clk_in), .arst_n_in(arst_n_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .pressure_in(pressure),
        .setpoint_active_out(act), .setpoint_oc_n_out(oc_n), .setpoint_error_out(err),
        .gauge_on_out(), .filament_two_out(), .missing_filament_fault_out(), .overpressure_out(),
        .analog_update_out(), .analog_level_out());
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic logic exp_state(input logic [31:0] v, input logic prev);
        return (v < 32'd1000) ? 1'b1 : (v > 32'd2000) ? 1'b0 : prev;
    endfunction
    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        @(posedge clk_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [9:0] a, input logic [31:0] m, input logic [31:0] exp);
        @(posedge clk_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
        #1 chk("read", reg_rdata_out & m, exp);
    endtask
    task automatic sp(input logic [31:0] v);
        @(posedge clk_in);
        target <= v;
    endtask
    task automatic hold(input int n, input logic v);
        repeat (n) @(posedge clk_in);
        #1 chk("held", {31'h0, act[0]}, {31'h0, v});
    endtask
    task automatic wait_act(input logic v, input int n);
        for (int i = 0; i < n && act[0] !== v; i++) @(posedge clk_in);
        #1 chk("active", {31'h0, act[0]}, {31'h0, v});
        chk("oc_n", {31'h0, oc_n[0]}, {31'h0, ~v});
    endtask
    task automatic summarize;
        $display("mismatches %0d comparisons %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #400000 n_errors++;
        summarize;
    end
    initial begin
        repeat (2) @(posedge clk_in);
        arst_n_in <= 1'b1;
        rd(10'h000, 32'h30, 32'h0);
        rd(10'h28C, 32'hFFFF_FFFF, 32'h434E_5631);
        rd(10'h3FC, 32'hFFFF_FFFF, 32'h0);
        wr(10'h004, 32'd1000);
        wr(10'h008, 32'd2000);
        wr(10'h000, 32'h5);
        sp(32'd500);
        wait_act(1'b1, 6);
        // boundaries first, then random readings across both thresholds
        for (int k = 0; k < 40; k++) begin
            p = (k == 0) ? 32'd1000 : (k == 1) ? 32'd2000 : ($random(seed) & 32'hFFF);
            exp_act = exp_state(p, exp_act);
            sp(p);
            hold(4, exp_act);
        end
        sp(32'd3000);
        wait_act(1'b0, 6);
        // two delay ticks: change lands 22 to 41 cycles after the crossing
        wr(10'h00C, 32'h0002_0002);
        sp(32'd500);
        hold(18, 1'b0);
        sp(32'd3000);
        hold(30, 1'b0);
        sp(32'd500);
        hold(18, 1'b0);
        wait_act(1'b1, 30);
        sp(32'd3000);
        hold(12, 1'b1);
        wait_act(1'b0, 35);
        wr(10'h004, 32'd3000);
        sp(32'd500);
        hold(60, 1'b0);
        chk("error", {24'h0, err}, 32'h1);
        wr(10'h004, 32'd1000);
        wait_act(1'b1, 60);
        wr(10'h000, 32'h25);
        wait_act(1'b0, 6);
        rd(10'h004, 32'hFFFF_FFFF, 32'd1000);
        rd(10'h00C, 32'hFFFF_FFFF, 32'h0002_0002);
        sp(32'd3000);
        wr(10'h000, 32'h15);
        hold(60, 1'b1);
        wr(10'h010, 32'h5);
        wr(10'h020, 32'h5);
        rd(10'h010, 32'hF, 32'h5);
        rd(10'h020, 32'hF, 32'h0);
        wr(10'h000, 32'h0);
        rd(10'h000, 32'h3F, 32'h20);
        rd(10'h004, 32'hFFFF_FFFF, 32'h0);
        rd(10'h00C, 32'hFFFF_FFFF, 32'h0);
        hold(4, 1'b0);
        // first hot gauge: single-filament model, linked to sensor 4, second filament asked
        wr(10'h200, 32'h0000_04A0);
        rd(10'h204, 32'hFFFF_FFFF, 32'h0001_00C8);
        rd(10'h214, 32'h6, 32'h6);
        sp(32'd9999);
        hold(4, 1'b0);
        rd(10'h214, 32'h2, 32'h2);
        sp(32'd10000);
        hold(4, 1'b0);
        rd(10'h214, 32'h2, 32'h0);
        wr(10'h204, 32'h0008_00C8);
        sp(32'd3000);
        hold(4, 1'b0);
        rd(10'h214, 32'hA, 32'h8);
        summarize;
    end
endmodule // pressure_setpoint_controller_bench
`default_nettype wire

// ===== verification/psc_sensor_model.sv
// sensor board stand-in: one 32-bit pressure reading per sensor
// assumes the bench names one sensor and its next reading at a time
`timescale 1ns/1ps
`default_nettype none
module psc_sensor_model #(parameter int NSENS = 12) (
    input wire logic clk_in,
    input wire logic [3:0] idx_in,
    input wire logic [31:0] target_in,
    output logic [NSENS*32-1:0] pressure_out
);
    initial pressure_out = {NSENS{32'h0000_0800}};
    // board refreshes the addressed reading each clock
    always @(posedge clk_in) pressure_out[idx_in*32+:32] <= target_in;
endmodule // psc_sensor_model
`default_nettype wire

// ===== verification/psc_setpoint_ctrl_asserts.sv
// port checker for the setpoint controller
// assumes one clock domain and an asynchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module psc_checker #(parameter int NSENS = 12, parameter int TICK_CYC = 2) (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic reg_rd_in,
    input wire logic [31:0] reg_rdata_out,
    input wire logic [7:0] setpoint_active_out,
    input wire logic [7:0] setpoint_oc_n_out,
    input wire logic [7:0] setpoint_error_out,
    input wire logic [NSENS-1:0] gauge_on_out,
    input wire logic [NSENS-1:0] filament_two_out,
    input wire logic [NSENS-1:0] missing_filament_fault_out,
    input wire logic [NSENS-1:0] analog_update_out,
    input wire logic [NSENS*32-1:0] analog_level_out
);
    localparam int GAP = 25 * TICK_CYC - 8;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);
    // first sensor of the rough kind paces at the slow rate
    sequence quiet_s;
        !analog_update_out[4] [*8];
    endsequence
    oc_inverse_a: assert property (setpoint_oc_n_out == ~setpoint_active_out)
        else $error("open collector not inverse of active");
    err_blocks_act_a: assert property
        ((setpoint_active_out & ~$past(setpoint_active_out) & $past(setpoint_error_out)) == 8'h00)
        else $error("channel activated while thresholds invalid");
    upd_single_a: assert property ((analog_update_out & $past(analog_update_out)) == '0)
        else $error("analog update longer than one cycle");
    upd_period_a: assert property (analog_update_out[4] |=> quiet_s ##GAP analog_update_out[4])
        else $error("slow analog update spacing wrong");
    level_pulse_a: assert property ($changed(analog_level_out[159:128]) |-> analog_update_out[4])
        else $error("analog level changed without update pulse");
    fil_excl_a: assert property ((filament_two_out & missing_filament_fault_out) == '0)
        else $error("second filament on while fault shown");
    cnv_on_a: assert property ($past(arst_n_in) |-> gauge_on_out[11:4] == 8'hFF)
        else $error("rough gauge not reported on");
    rd_idle_a: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
        else $error("read data outside its cycle");
endmodule // psc_checker
bind psc_setpoint_ctrl psc_checker #(.NSENS(NSENS), .TICK_CYC(TICK_CYC)) i_psc_checker (
    .clk_in, .arst_n_in, .reg_rd_in, .reg_rdata_out, .setpoint_active_out, .setpoint_oc_n_out,
    .setpoint_error_out, .gauge_on_out, .filament_two_out, .missing_filament_fault_out,
    .analog_update_out, .analog_level_out);
`default_nettype wire
